// File: rtl/efb_defines.vh
// Purpose: Shared constants of the encapsulation frame builder
// Assumes: 50 MHz hclk, 32-bit AHB-Lite register bus
// Notes:   Definitions only
`ifndef EFB_DEFINES_VH
`define EFB_DEFINES_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define EFB_ADDR_CTRL      8'h00
`define EFB_ADDR_BLKPOS    8'h04
`define EFB_ADDR_FRAMES    8'h08
`define EFB_ADDR_STATUS    8'h0C

// CTRL fields and reset values
`define EFB_CTRL_SYNC_EN   0
`define EFB_CTRL_TYPE_LO   1
`define EFB_CTRL_TYPE_HI   2
`define EFB_TYPE_TS        2'h3
`define EFB_TYPE_GS        2'h1
`define EFB_CTRL_RST       1'h0

// ****************************************
// Frame layout
// ****************************************
`define EFB_SYNC_RST       8'h47
`define EFB_PKT_LEN_BITS   16'h05E0
`define EFB_PAY_LEN_BITS   16'h2F40
`define EFB_RESERVED_VAL   32'h00000000
`define EFB_PKT_PER_FIELD  3'h7
`define EFB_PKT_DATA_BITS  11'h5D8
`define EFB_HDR_BITS       11'h072
`define EFB_HDR_CRC_FROM   11'h062
`define EFB_CRC_BITS       11'h010
`define EFB_PAD_BITS       11'h048
`define EFB_CRC_POLY       16'h1021
`define EFB_CRC_PRESET     16'hFFFF
`define EFB_BLK_RST        10'h3FF

`endif

// File: rtl/efb_frame_builder.v
// Purpose: Builds constant-length encapsulation frames from 188-byte packets
// Assumes: Byte source and bit sink run on hclk; one register slave on AHB-Lite
// Notes:   Serial output, one bit per accepted beat
//
// Contract
// - Payload field holds exactly eight packets
// - Packet checksum uses polynomial x16+x12+x5+1
// - Checksum register preset to all ones
// - Checksum covers packet minus sync byte
// - Drop sync byte, append checksum after packet
// - 114-bit header precedes each payload field
// - Header fields in documented fixed order
// - Input type 11 stream, 01 generic
// - Packet length field is 1504 bits
// - Payload length field is 12096 bits
// - Sync copy then 32-bit reserved field
// - Position counter: 14-bit superframe, 10-bit block
// - Superframe number zero without service sync
// - Superframe number counts, clears on service zero
// - Block index zero at superframe start, increments
// - Header checksum over first 98 header bits
// - Zero padding to 12282-bit frame
// - Frame length constant for every code rate
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "efb_defines.vh"

module efb_frame_builder (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata_q,
    output reg         hreadyout_q,
    output reg         hresp_q,
    // Superframe timing from the scheduler
    input  wire        sf_start,
    input  wire        sf_service0,
    // Packet byte input
    input  wire        in_valid,
    input  wire [7:0]  in_data,
    output reg         in_ready_q,
    // Frame bit output
    output reg         out_valid_q,
    output reg         out_bit_q,
    output reg         out_sof_q,
    input  wire        out_ready
);

    // ****************************************
    // States
    // ****************************************
    localparam [4:0] ST_SYNC = 5'h01;
    localparam [4:0] ST_HDR  = 5'h02;
    localparam [4:0] ST_PAY  = 5'h04;
    localparam [4:0] ST_PCRC = 5'h08;
    localparam [4:0] ST_PAD  = 5'h10;

    reg  [4:0]  st_q;
    reg  [4:0]  st_d;
    reg  [10:0] cnt_q;
    reg  [10:0] cnt_d;
    reg  [2:0]  pkt_q;
    reg  [7:0]  byte_q;
    reg  [3:0]  bits_q;
    reg  [3:0]  bits_d;
    reg  [97:0] hdr_q;
    reg  [15:0] crc_q;
    reg  [7:0]  sync_q;
    reg  [13:0] sh_q;
    reg  [9:0]  blk_q;
    reg         sf_pend_q;
    reg         sf_svc0_q;
    reg  [31:0] frames_q;
    reg         sync_en_q;
    reg  [1:0]  type_q;
    reg         ap_wr_q;
    reg  [7:0]  ap_addr_q;
    reg         bit_val;
    reg         crc_feed;
    reg  [13:0] sh_d;
    reg  [9:0]  blk_d;
    reg  [31:0] rd_val;

    wire        step;
    wire        take;
    wire        emit;
    wire        crc_fb;
    wire [15:0] crc_upd;
    wire        ap_ok;

    // ****************************************
    // Handshakes
    // ****************************************
    // Output register empties or drains; a stall holds bit emission, but byte takes still proceed
    assign step = !out_valid_q || out_ready;
    assign take = in_valid && in_ready_q;
    assign emit = step && (st_q == ST_HDR || st_q == ST_PCRC || st_q == ST_PAD
                  || (st_q == ST_PAY && bits_q != 4'h0));

    // Serial MSB-first checksum, shared by header and packets
    assign crc_fb  = crc_q[15] ^ bit_val;
    assign crc_upd = {crc_q[14:0], 1'b0} ^ (crc_fb ? `EFB_CRC_POLY : 16'h0000);

    // Bit selection for the current state
    always @* begin
        bit_val  = 1'b0;
        crc_feed = 1'b0;
        case (st_q)
            ST_HDR: begin
                if (cnt_q < `EFB_HDR_CRC_FROM) begin
                    bit_val  = hdr_q[97];
                    crc_feed = 1'b1;
                end else begin
                    bit_val = crc_q[15];
                end
            end
            ST_PAY: begin
                bit_val  = byte_q[7];
                crc_feed = 1'b1;
            end
            ST_PCRC: bit_val = crc_q[15];
            ST_PAD:  bit_val = 1'b0;
            default: bit_val = 1'b0;
        endcase
    end

    // Position counter for the next frame
    always @* begin
        if (sf_pend_q) begin
            blk_d = 10'h000;
            sh_d  = sf_svc0_q ? 14'h0000 : sh_q + 14'h0001;
        end else begin
            blk_d = blk_q + 10'h001;
            sh_d  = sh_q;
        end
        if (!sync_en_q) begin
            sh_d = 14'h0000;
        end
    end

    // ****************************************
    // Sequencer next state
    // ****************************************
    always @* begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        bits_d = bits_q;
        case (st_q)
            ST_SYNC: begin
                if (take) begin
                    cnt_d = 11'h000;
                    st_d  = (pkt_q == 3'h0) ? ST_HDR : ST_PAY;
                end
            end
            ST_HDR: begin
                if (emit) begin
                    cnt_d = cnt_q + 11'h001;
                    if (cnt_d == `EFB_HDR_BITS) begin
                        cnt_d = 11'h000;
                        st_d  = ST_PAY;
                    end
                end
            end
            ST_PAY: begin
                if (take) begin
                    bits_d = 4'h8;
                end else if (emit) begin
                    bits_d = bits_q - 4'h1;
                    cnt_d  = cnt_q + 11'h001;
                    if (cnt_d == `EFB_PKT_DATA_BITS) begin
                        cnt_d = 11'h000;
                        st_d  = ST_PCRC;
                    end
                end
            end
            ST_PCRC: begin
                if (emit) begin
                    cnt_d = cnt_q + 11'h001;
                    if (cnt_d == `EFB_CRC_BITS) begin
                        cnt_d = 11'h000;
                        st_d  = (pkt_q == `EFB_PKT_PER_FIELD) ? ST_PAD : ST_SYNC;
                    end
                end
            end
            ST_PAD: begin
                if (emit) begin
                    cnt_d = cnt_q + 11'h001;
                    if (cnt_d == `EFB_PAD_BITS) begin
                        cnt_d = 11'h000;
                        st_d  = ST_SYNC;
                    end
                end
            end
            default: st_d = ST_SYNC;
        endcase
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q       <= ST_SYNC;
            cnt_q      <= 11'h000;
            pkt_q      <= 3'h0;
            byte_q     <= 8'h00;
            bits_q     <= 4'h0;
            hdr_q      <= 98'h0;
            crc_q      <= `EFB_CRC_PRESET;
            sync_q     <= `EFB_SYNC_RST;
            sh_q       <= 14'h0000;
            blk_q      <= `EFB_BLK_RST;
            frames_q   <= 32'h00000000;
            in_ready_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            bits_q <= bits_d;
            // Ready is registered from the next state, so it drops
            // for the whole header, checksum and padding insertion
            in_ready_q <= (st_d == ST_SYNC) ||
                          (st_d == ST_PAY && bits_d == 4'h0);
            if (st_q == ST_SYNC && take) begin
                sync_q <= in_data;
                crc_q  <= `EFB_CRC_PRESET;
                if (pkt_q == 3'h0) begin
                    sh_q  <= sh_d;
                    blk_q <= blk_d;
                    hdr_q <= {type_q, `EFB_PKT_LEN_BITS, `EFB_PAY_LEN_BITS,
                              in_data, `EFB_RESERVED_VAL, sh_d, blk_d};
                end
            end else if (st_q == ST_PAY && take) begin
                byte_q <= in_data;
            end else if (emit) begin
                if (crc_feed) begin
                    crc_q <= crc_upd;
                end else begin
                    crc_q <= {crc_q[14:0], 1'b0};
                end
                if (st_q == ST_HDR) begin
                    hdr_q <= {hdr_q[96:0], 1'b0};
                    // Preset before the first packet checksum
                    if (st_d == ST_PAY) begin
                        crc_q <= `EFB_CRC_PRESET;
                    end
                end
                if (st_q == ST_PAY) begin
                    byte_q <= {byte_q[6:0], 1'b0};
                end
                if (st_q == ST_PCRC && st_d != ST_PCRC) begin
                    pkt_q <= pkt_q + 3'h1;
                end
                if (st_q == ST_PAD && st_d == ST_SYNC) begin
                    frames_q <= frames_q + 32'h00000001;
                end
            end
        end
    end

    // ****************************************
    // Superframe pending flag
    // ****************************************
    // A start that lands on the consuming cycle sets again and wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sf_pend_q <= 1'b0;
            sf_svc0_q <= 1'b0;
        end else if (sf_start) begin
            sf_pend_q <= 1'b1;
            sf_svc0_q <= sf_service0;
        end else if (st_q == ST_SYNC && take && pkt_q == 3'h0) begin
            sf_pend_q <= 1'b0;
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid_q <= 1'b0;
            out_bit_q   <= 1'b0;
            out_sof_q   <= 1'b0;
        end else if (step) begin
            out_valid_q <= emit;
            out_bit_q   <= emit & bit_val;
            out_sof_q   <= emit && st_q == ST_HDR && cnt_q == 11'h000;
        end
    end

    // ****************************************
    // AHB-Lite register slave
    // ****************************************
    assign ap_ok = hsel && htrans[1] && hready;

    // Bypass a write still in its data phase so read-after-write is fresh
    always @* begin
        rd_val = 32'h00000000;
        case (haddr[7:0])
            `EFB_ADDR_CTRL: begin
                if (ap_wr_q && ap_addr_q == `EFB_ADDR_CTRL) begin
                    rd_val = {29'h0, hwdata[2:0]};
                end else begin
                    rd_val = {29'h0, type_q, sync_en_q};
                end
            end
            `EFB_ADDR_BLKPOS: rd_val = {8'h00, sh_q, blk_q};
            `EFB_ADDR_FRAMES: rd_val = frames_q;
            `EFB_ADDR_STATUS: rd_val = {16'h0000, sync_q, pkt_q, st_q};
            default:          rd_val = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q     <= 1'b0;
            ap_addr_q   <= 8'h00;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            sync_en_q   <= `EFB_CTRL_RST;
            type_q      <= `EFB_TYPE_TS;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            if (hready) begin
                ap_wr_q   <= ap_ok && hwrite && hsize == 3'h2 && haddr[31:8] == 24'h0;
                ap_addr_q <= haddr[7:0];
                hrdata_q  <= (ap_ok && !hwrite) ? rd_val : 32'h00000000;
            end
            if (ap_wr_q && ap_addr_q == `EFB_ADDR_CTRL) begin
                sync_en_q <= hwdata[`EFB_CTRL_SYNC_EN];
                type_q    <= hwdata[`EFB_CTRL_TYPE_HI:`EFB_CTRL_TYPE_LO];
            end
        end
    end

endmodule // efb_frame_builder

`default_nettype wire

// File: tb/efb_frame_checker_properties.sv
// Purpose: Concurrent checks on the frame builder stream ports
// Assumes: One clock domain, hresetn active low
// Notes:   Bit index counter restarts on every consumed start strobe
`timescale 1ns/1ps
`default_nettype none
`include "efb_defines.vh"

module efb_frame_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Stream ports
    input wire logic in_valid,
    input wire logic in_ready_q,
    input wire logic out_valid_q,
    input wire logic out_bit_q,
    input wire logic out_sof_q,
    input wire logic out_ready
);
    localparam logic [31:0] LEN_FIELDS = {`EFB_PKT_LEN_BITS, `EFB_PAY_LEN_BITS};
    logic        take_bit;
    logic [13:0] cnt_q;
    logic [13:0] cnt_d;
    assign take_bit = out_valid_q & out_ready;
    assign cnt_d    = out_sof_q ? 14'h0001 : cnt_q + 14'h0001;
    // Starts at a full frame so the very first bit must carry the strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_q <= 14'h2FFA;
        else if (take_bit) cnt_q <= cnt_d;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_byte_take;
        in_valid && in_ready_q;
    endsequence
    sequence s_bit_held;
        out_valid_q && !out_ready;
    endsequence
    AST_BYTE_SHIFT: assert property (s_byte_take ##1 !in_ready_q |=> !in_ready_q [*7])
        else $error("input ready rose during byte shift");
    AST_BIT_HOLD: assert property (s_bit_held |=> out_valid_q && $stable(out_bit_q))
        else $error("output bit changed while stalled");
    AST_FRAME_LEN: assert property (take_bit |-> (out_sof_q == (cnt_q == 14'h2FFA)))
        else $error("frame length is not constant");
    AST_SOF_PULSE: assert property (take_bit && out_sof_q |=> !out_sof_q)
        else $error("start strobe on a second bit");
    AST_HDR_STALL: assert property (out_valid_q
        && (out_sof_q || cnt_q < 14'h0071) |-> !in_ready_q)
        else $error("input accepted during header");
    AST_LEN_FIELDS: assert property (take_bit && cnt_q >= 14'h0002
        && cnt_q <= 14'h0021 |-> out_bit_q == LEN_FIELDS[14'h0021 - cnt_q])
        else $error("length field bit wrong");
    AST_RESERVED: assert property (take_bit && cnt_q >= 14'h002A
        && cnt_q <= 14'h0049 |-> !out_bit_q)
        else $error("reserved field bit set");
    AST_PAD: assert property (take_bit && !out_sof_q && cnt_q >= 14'h2FB2 |-> !out_bit_q)
        else $error("padding bit set");
endmodule // efb_frame_checker

bind efb_frame_builder efb_frame_checker i_chk (.hclk(hclk), .hresetn(hresetn),
    .in_valid(in_valid), .in_ready_q(in_ready_q), .out_valid_q(out_valid_q),
    .out_bit_q(out_bit_q), .out_sof_q(out_sof_q), .out_ready(out_ready));
`default_nettype wire

// File: tb/efb_stream_partner.sv
// Purpose: Packet byte source and stalling bit sink around the builder
// Assumes: Source always has data; sink stalls one cycle in sixteen
// Notes:   Captured frame bits are read by the bench after each frame
`timescale 1ns/1ps
`default_nettype none

module efb_stream_partner (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Byte source
    output logic            in_valid,
    output logic [7:0]      in_data,
    input  wire logic       in_ready_q,
    // Bit sink
    input  wire logic       out_valid_q,
    input  wire logic       out_bit_q,
    input  wire logic       out_sof_q,
    output logic            out_ready
);
    int unsigned pkt, pos, idx, frames;
    logic [3:0]  stall;
    logic        fbits [0:12281];
    function automatic logic [7:0] pkt_byte(input int unsigned p, input int unsigned j);
        return (j == 0) ? 8'h47 : 8'((p * 13) + j);
    endfunction
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_valid  <= 1'b0;
            in_data   <= 8'h00;
            {pkt, pos, idx, frames} <= '0;
            stall     <= 4'h0;
            out_ready <= 1'b0;
        end else begin
            stall     <= stall + 4'h1;
            out_ready <= (stall != 4'h5);
            in_valid  <= 1'b1;
            if (!in_valid) in_data <= pkt_byte(pkt, pos);
            // Byte held until taken; 188 per packet, sync first
            if (in_valid && in_ready_q) begin
                pos     <= (pos == 187) ? 0 : pos + 1;
                pkt     <= (pos == 187) ? pkt + 1 : pkt;
                in_data <= (pos == 187) ? pkt_byte(pkt + 1, 0) : pkt_byte(pkt, pos + 1);
            end
            if (out_valid_q && out_ready) begin
                fbits[out_sof_q ? 0 : idx] <= out_bit_q;
                idx <= out_sof_q ? 1 : idx + 1;
                if (!out_sof_q && idx == 12281) frames <= frames + 1;
            end
        end
    end
endmodule // efb_stream_partner
`default_nettype wire

// File: tb/encap_frame_builder_tb.sv
// Purpose: Frame content, counter and register tests of the builder
// Assumes: hready fed back from hreadyout_q, single word transfers
// Notes:   Expected frames are rebuilt from the source byte pattern
`timescale 1ns/1ps
`default_nettype none
`include "efb_defines.vh"

module encap_frame_builder_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, sf_start, sf_service0;
    logic [31:0] haddr, hwdata, hrdata_q, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout_q, hresp_q, in_valid, in_ready_q;
    logic        out_valid_q, out_bit_q, out_sof_q, out_ready;
    logic [7:0]  in_data;
    int          num_errors, tests_run;
    assign hready = hreadyout_q;

    efb_frame_builder i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
        .sf_start(sf_start), .sf_service0(sf_service0), .in_valid(in_valid),
        .in_data(in_data), .in_ready_q(in_ready_q), .out_valid_q(out_valid_q),
        .out_bit_q(out_bit_q), .out_sof_q(out_sof_q), .out_ready(out_ready));
    efb_stream_partner i_partner (.hclk(hclk), .hresetn(hresetn), .in_valid(in_valid),
        .in_data(in_data), .in_ready_q(in_ready_q), .out_valid_q(out_valid_q),
        .out_bit_q(out_bit_q), .out_sof_q(out_sof_q), .out_ready(out_ready));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim;
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata_q;
    endtask
    task automatic sf_pulse(input logic svc0);
        repeat (200) @(posedge hclk);
        sf_start <= 1'b1; sf_service0 <= svc0;
        @(posedge hclk);
        sf_start <= 1'b0;
    endtask
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `EFB_CRC_POLY : 16'h0000);
    endfunction
    task automatic check_frame(input int unsigned k, input logic [13:0] sfn, input logic [9:0] blk);
        logic [113:0] hdr;
        logic [127:0] got;
        logic [15:0]  c;
        logic [7:0]   byt;
        int unsigned  n, bad;
        wait (i_partner.frames == k + 1);
        // Let the last captured bit settle before reading the buffer
        @(negedge hclk);
        hdr = {2'h3, `EFB_PKT_LEN_BITS, `EFB_PAY_LEN_BITS, 8'h47, 32'h0, sfn, blk, 16'h0};
        c = `EFB_CRC_PRESET;
        for (int i = 113; i >= 16; i--) c = crc_step(c, hdr[i]);
        hdr[15:0] = c;
        got = '0;
        for (int i = 0; i < 114; i++) got = {got[126:0], i_partner.fbits[i]};
        check(got, hdr);
        n = 114;
        bad = 0;
        for (int p = 0; p < 8; p++) begin
            c = `EFB_CRC_PRESET;
            for (int j = 1; j < 188; j++) begin
                byt = i_partner.pkt_byte(8 * k + p, j);
                for (int b = 7; b >= 0; b--) begin
                    c = crc_step(c, byt[b]);
                    bad += (i_partner.fbits[n] !== byt[b]);
                    n++;
                end
            end
            for (int b = 15; b >= 0; b--) begin
                bad += (i_partner.fbits[n] !== c[b]);
                n++;
            end
        end
        check(bad, 0);
        bad = 0;
        for (int i = n; i < 12282; i++) bad += (i_partner.fbits[i] !== 1'b0);
        check(bad, 0);
    endtask

    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        end_sim();
    end
    initial begin
        {hsel, hwrite, sf_start, sf_service0} = '0;
        {haddr, hwdata, rd} = '0;
        htrans = 2'h0;
        hsize = 3'h2;
        num_errors = 0;
        tests_run = 0;
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `EFB_ADDR_CTRL, 32'h0);
        check(rd, 32'h6);
        check(hresp_q, 1'b0);
        ahb(1'b1, `EFB_ADDR_CTRL, 32'h3);
        ahb(1'b1, 32'h10, 32'hFFFFFFFF);
        ahb(1'b0, `EFB_ADDR_CTRL, 32'h0);
        check(rd, 32'h3);
        ahb(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, `EFB_ADDR_CTRL, 32'h6);
        // Superframe without service zero while sync is off: number stays 0
        sf_pulse(1'b0);
        check_frame(0, 14'h0, 10'h0);
        ahb(1'b1, `EFB_ADDR_CTRL, 32'h7);
        check_frame(1, 14'h0, 10'h0);
        sf_pulse(1'b0);
        check_frame(2, 14'h0, 10'h1);
        sf_pulse(1'b1);
        ahb(1'b0, `EFB_ADDR_BLKPOS, 32'h0);
        check(rd, 32'h400);
        check_frame(3, 14'h1, 10'h0);
        check_frame(4, 14'h0, 10'h0);
        ahb(1'b0, `EFB_ADDR_FRAMES, 32'h0);
        check(rd, 32'h5);
        end_sim();
    end
endmodule // encap_frame_builder_tb
`default_nettype wire
